// >>> fcrs_char_match.sv
// eight-bit comparison of each received character against the three compare values
`timescale 1ns/1ps
`default_nettype none

module fcrs_char_match (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // received character
  input  wire logic       rxCharValid,
  input  wire logic [7:0] rxChar,
  // compare values
  input  wire logic [7:0] resumeCompare,
  input  wire logic [7:0] pauseCompare,
  input  wire logic [7:0] wakeCompare,
  // one pulse per matching register
  output logic            resumeMatch,
  output logic            pauseMatch,
  output logic            wakeMatch
);

  logic next_resumeMatch;
  logic next_pauseMatch;
  logic next_wakeMatch;

  always_comb begin
    next_resumeMatch = rxCharValid && (rxChar == resumeCompare); // [R17]
    next_pauseMatch  = rxCharValid && (rxChar == pauseCompare);  // [R17]
    next_wakeMatch   = rxCharValid && (rxChar == wakeCompare);   // [R17]
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      resumeMatch <= 1'b0;
      pauseMatch  <= 1'b0;
      wakeMatch   <= 1'b0;
    end else begin
      resumeMatch <= next_resumeMatch;
      pauseMatch  <= next_pauseMatch;
      wakeMatch   <= next_wakeMatch;
    end
  end

endmodule

`default_nettype wire

// >>> fcrs_chk.sv
// concurrent checks of the flow character block, seen from its ports
`timescale 1ns/1ps
`default_nettype none

module fcrs_chk (
  // clock and reset
  input wire logic       clk,
  input wire logic       reset,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdData,
  // receive and transmit side
  input wire logic       rxCharValid,
  input wire logic [7:0] rxChar,
  input wire logic       bitTick,
  input wire logic       pauseSendRequest,
  input wire logic       resumeSendRequest,
  input wire logic       autoPauseSent,
  input wire logic       autoResumeSent,
  input wire logic       txHalt,
  input wire logic       txSendPause,
  input wire logic       txSendResume,
  input wire logic       autoRxFlowEnable,
  input wire logic       resumeSeen,
  input wire logic       pauseSeen
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  logic [7:0] resumeCmp;
  logic [7:0] pendTicks;
  logic       rdStat;

  assign rdStat = regRead && regAddr == 8'h44;

  ////////////////////////////////////////////////////////////////////////////
  // shadow of the resume compare, so a match can be predicted
  always_ff @(posedge clk) begin
    if (reset)
      resumeCmp <= 8'h11;
    else if (regWrite && regAddr == 8'h41)
      resumeCmp <= regWrData;
  end

  // bit times spent in a pending send state
  always_ff @(posedge clk) begin
    if (reset || !(txSendPause || txSendResume))
      pendTicks <= 8'h00;
    else if (bitTick)
      pendTicks <= pendTicks + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  rd_idle_a: assert property (!regRead |=> regRdData == 8'h00)
    else $error("read data not zero outside its slot");
  resume_match_a: assert property (
    rxCharValid && rxChar == resumeCmp |-> ##2 resumeSeen)
    else $error("resume match pulse missing");
  pause_cause_a: assert property (pauseSeen |-> $past(rxCharValid, 2))
    else $error("pause pulse without a character");
  halt_release_a: assert property (resumeSeen |-> !txHalt)
    else $error("halt kept after resume");
  pend_excl_a: assert property (!(txSendPause && txSendResume))
    else $error("both sends pending");
  pend_bound_a: assert property (pendTicks <= 8'h0C)
    else $error("send pending too long");
  resume_pend_a: assert property (
    resumeSendRequest && !pauseSendRequest && !autoPauseSent && !autoResumeSent
    && !txSendPause && !txSendResume |=> txSendResume)
    else $error("resume request not pending");
  sent_idle_a: assert property (
    (autoPauseSent || autoResumeSent) && !pauseSendRequest && !resumeSendRequest
    |=> !txSendPause && !txSendResume)
    else $error("pending kept after send");
  auto_off_a: assert property (
    rdStat && !autoRxFlowEnable |=> regRdData[5:4] == 2'b00)
    else $error("sent field set while auto flow off");
  rd_clear_a: assert property (
    (!rxCharValid) [*3] ##0 rdStat ##1 (rdStat && !rxCharValid)
    |=> regRdData[7:6] == 2'b00)
    else $error("seen field not cleared by read");
endmodule

bind fcrs_top fcrs_chk i_chk (
  .clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .rxCharValid(rxCharValid), .rxChar(rxChar), .bitTick(bitTick),
  .pauseSendRequest(pauseSendRequest), .resumeSendRequest(resumeSendRequest),
  .autoPauseSent(autoPauseSent), .autoResumeSent(autoResumeSent), .txHalt(txHalt),
  .txSendPause(txSendPause), .txSendResume(txSendResume),
  .autoRxFlowEnable(autoRxFlowEnable), .resumeSeen(resumeSeen), .pauseSeen(pauseSeen)
);

`default_nettype wire

// >>> fcrs_params.svh
// offsets, field positions, reset values and counts of the flow character block
`ifndef FCRS_PARAMS_SVH
`define FCRS_PARAMS_SVH

// register offsets on the side bus
`define FCRS_OFS_RESUME_CMP   8'h41
`define FCRS_OFS_PAUSE_CMP    8'h42
`define FCRS_OFS_WAKE_CMP     8'h43
`define FCRS_OFS_FLOW_STATUS  8'h44
`define FCRS_OFS_CONTROL      8'h48
`define FCRS_OFS_INT_STATUS   8'h49
`define FCRS_OFS_INT_MASK     8'h4A

// reset values
`define FCRS_RST_RESUME_CMP   8'h11
`define FCRS_RST_PAUSE_CMP    8'h13
`define FCRS_RST_WAKE_CMP     8'h00
`define FCRS_RST_CONTROL      8'h00
`define FCRS_RST_INT_MASK     8'h00

// control register fields
`define FCRS_CTL_AUTO_RX_FLOW 0
`define FCRS_CTL_TX_FLOW      1

// flow status fields
`define FCRS_FS_RX_PAUSE      6
`define FCRS_FS_RX_RESUME     7
`define FCRS_FS_TX_RESUME     4
`define FCRS_FS_TX_PAUSE      5

// interrupt status and mask fields
`define FCRS_INT_RESUME_RX    0
`define FCRS_INT_PAUSE_RX     1
`define FCRS_INT_WAKE_RX      2
`define FCRS_INT_TX_HALTED    3
`define FCRS_INT_BITS         4

// longest frame in bit times: start, eight data, parity, two stop
`define FCRS_CHAR_BITS        4'hC

`endif

// >>> fcrs_pkg.sv
// types of the flow character recognition and status block
package fcrs_pkg;

  typedef enum logic [1:0] {
    FLOW_NORMAL,
    FLOW_HALT_PEND,
    FLOW_HALTED,
    FLOW_RESTARTED
  } fcrs_flow_t;

  typedef enum logic [1:0] {
    LINE_NORMAL,
    LINE_IDLE_WAIT,
    LINE_PAUSE_PEND,
    LINE_RESUME_PEND
  } fcrs_line_t;

endpackage

// >>> fcrs_remote_station.sv
// remote serial station handing whole received characters to the block
`timescale 1ns/1ps
`default_nettype none

module fcrs_remote_station (
  // clock
  input  wire logic       clk,
  // received character
  output var  logic       rxCharValid,
  output var  logic [7:0] rxChar
);
  initial begin
    rxCharValid = 1'b0;
    rxChar = 8'h00;
  end

  // inverse between characters, so stale data never matches by luck
  task automatic sendChar(input logic [7:0] c);
    @(posedge clk);
    rxCharValid <= 1'b1;
    rxChar <= c;
    @(posedge clk);
    rxCharValid <= 1'b0;
    rxChar <= ~c;
    repeat (3) @(posedge clk);
  endtask
endmodule

`default_nettype wire

// >>> fcrs_top.sv
// flow character recognition, flow status register and interrupt of one uart channel
//
// Function
// [R1] resume compare register, eight bits, resets to 0x11.
// [R2] pause compare register, eight bits, resets to 0x13.
// [R3] wake address compare register, eight bits, resets to 0x00.
// [R4] reading flow status returns bits 7:4 then clears them.
// [R5] bits 7:6: 01 pause seen, 10 resume seen, 11 both.
// [R6] received indications stay set until the next status read.
// [R7] received field updates on every match whatever the modes or mask.
// [R8] bits 5:4: last auto flow char sent, 01 resume, 10 pause, 11 both.
// [R9] sent field reads 00 and is cleared while auto receiver flow is off.
// [R10] software leaving auto mode after a pause must send resume itself.
// [R11] bits 3:2 at 00: transmitter runs unaffected by flow characters.
// [R12] 01 halt pending; stop after current character, then field becomes 11.
// [R13] 10 restarted after halt; a status read returns it to normal.
// [R14] 11 transmitter stopped by received pause character.
// [R15] bits 1:0: normal, idle wait, pause pending, resume pending.
// [R16] pending send states end within one character time.
// [R17] each received character compared on eight bits, one pulse per register.
`timescale 1ns/1ps
`default_nettype none
`include "fcrs_params.svh"

module fcrs_top
  import fcrs_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // register port
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdData,
  // receiver
  input  wire logic       rxCharValid,
  input  wire logic [7:0] rxChar,
  // transmitter engine
  input  wire logic       bitTick,
  input  wire logic       txActive,
  input  wire logic       txCharDone,
  input  wire logic       txFifoEmpty,
  input  wire logic       pauseSendRequest,
  input  wire logic       resumeSendRequest,
  input  wire logic       autoPauseSent,
  input  wire logic       autoResumeSent,
  output logic            txHalt,
  output logic            txSendPause,
  output logic            txSendResume,
  output logic            autoRxFlowEnable,
  // recognition pulses
  output logic            resumeSeen,
  output logic            pauseSeen,
  output logic            wakeSeen,
  // interrupt
  output logic            irq
);

  function automatic logic regHit(input logic [7:0] addr, input logic [7:0] offset);
    regHit = (addr == offset);
  endfunction

  logic                       resumeMatch;
  logic                       pauseMatch;
  logic                       wakeMatch;
  logic [7:0]                 resumeCompare;
  logic [7:0]                 pauseCompare;
  logic [7:0]                 wakeCompare;
  logic [7:0]                 control;
  logic [1:0]                 rxField;
  logic [1:0]                 txSentField;
  logic [`FCRS_INT_BITS-1:0]  intStatus;
  logic [`FCRS_INT_BITS-1:0]  intMask;
  fcrs_flow_t                 flowState;
  fcrs_line_t                 lineState;
  logic [3:0]                 bitCount;
  logic [7:0]                 next_resumeCompare;
  logic [7:0]                 next_pauseCompare;
  logic [7:0]                 next_wakeCompare;
  logic [7:0]                 next_control;
  logic [1:0]                 next_rxField;
  logic [1:0]                 next_txSentField;
  logic [`FCRS_INT_BITS-1:0]  next_intStatus;
  logic [`FCRS_INT_BITS-1:0]  next_intMask;
  fcrs_flow_t                 next_flowState;
  fcrs_line_t                 next_lineState;
  logic [3:0]                 next_bitCount;
  logic [7:0]                 next_regRdData;
  logic [7:0]                 flowStatus;
  logic [1:0]                 flowField;
  logic [1:0]                 lineField;
  logic                       statusRead;
  logic                       flowCtlOn;
  logic                       haltedEvent;

  fcrs_char_match u_match (
    .clk           (clk),
    .reset         (reset),
    .rxCharValid   (rxCharValid),
    .rxChar        (rxChar),
    .resumeCompare (resumeCompare),
    .pauseCompare  (pauseCompare),
    .wakeCompare   (wakeCompare),
    .resumeMatch   (resumeMatch),
    .pauseMatch    (pauseMatch),
    .wakeMatch     (wakeMatch)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // writable registers

  assign statusRead = regRead && regHit(regAddr, `FCRS_OFS_FLOW_STATUS);
  assign flowCtlOn  = control[`FCRS_CTL_TX_FLOW];

  always_comb begin
    next_resumeCompare = resumeCompare;
    next_pauseCompare  = pauseCompare;
    next_wakeCompare   = wakeCompare;
    next_control       = control;
    next_intMask       = intMask;
    if (regWrite) begin
      if (regHit(regAddr, `FCRS_OFS_RESUME_CMP)) begin
        next_resumeCompare = regWrData; // [R1]
      end
      if (regHit(regAddr, `FCRS_OFS_PAUSE_CMP)) begin
        next_pauseCompare = regWrData; // [R2]
      end
      if (regHit(regAddr, `FCRS_OFS_WAKE_CMP)) begin
        next_wakeCompare = regWrData; // [R3]
      end
      if (regHit(regAddr, `FCRS_OFS_CONTROL)) begin
        next_control = {6'h00, regWrData[1:0]};
      end
      if (regHit(regAddr, `FCRS_OFS_INT_MASK)) begin
        next_intMask = regWrData[`FCRS_INT_BITS-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      resumeCompare <= `FCRS_RST_RESUME_CMP; // [R1]
      pauseCompare  <= `FCRS_RST_PAUSE_CMP;  // [R2]
      wakeCompare   <= `FCRS_RST_WAKE_CMP;   // [R3]
      control       <= `FCRS_RST_CONTROL;
      intMask       <= 4'(`FCRS_RST_INT_MASK);
    end else begin
      resumeCompare <= next_resumeCompare;
      pauseCompare  <= next_pauseCompare;
      wakeCompare   <= next_wakeCompare;
      control       <= next_control;
      intMask       <= next_intMask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sticky received and sent fields; a new event in the read cycle survives

  always_comb begin
    next_rxField = rxField;
    if (statusRead) begin
      next_rxField = 2'h0; // [R4] [R6]
    end
    // no mode or mask term here, so the field works as a plain detector
    if (pauseMatch) begin
      next_rxField[`FCRS_FS_RX_PAUSE-6] = 1'b1; // [R5] [R7]
    end
    if (resumeMatch) begin
      next_rxField[`FCRS_FS_RX_RESUME-6] = 1'b1; // [R5] [R7]
    end

    next_txSentField = txSentField;
    if (statusRead) begin
      next_txSentField = 2'h0; // [R4]
    end
    if (autoResumeSent) begin
      next_txSentField[`FCRS_FS_TX_RESUME-4] = 1'b1; // [R8]
    end
    if (autoPauseSent) begin
      next_txSentField[`FCRS_FS_TX_PAUSE-4] = 1'b1; // [R8]
    end
    // leaving auto mode drops the record; software then owes the resume itself
    if (!next_control[`FCRS_CTL_AUTO_RX_FLOW]) begin
      next_txSentField = 2'h0; // [R9] [R10]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rxField     <= 2'h0;
      txSentField <= 2'h0;
    end else begin
      rxField     <= next_rxField;
      txSentField <= next_txSentField;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // transmitter flow state, bits 3:2

  always_comb begin
    next_flowState = flowState;
    unique case (flowState)
      FLOW_NORMAL, FLOW_RESTARTED: begin
        if (flowCtlOn && pauseMatch) begin
          // a character on the line is never cut short
          next_flowState = txActive ? FLOW_HALT_PEND : FLOW_HALTED; // [R12] [R14]
        end else if (flowState == FLOW_RESTARTED && statusRead) begin
          next_flowState = FLOW_NORMAL; // [R13]
        end
      end
      FLOW_HALT_PEND: begin
        if (resumeMatch) begin
          next_flowState = FLOW_NORMAL;
        end else if (txCharDone || !txActive) begin
          next_flowState = FLOW_HALTED; // [R12]
        end
      end
      FLOW_HALTED: begin
        if (resumeMatch) begin
          next_flowState = FLOW_RESTARTED; // [R13]
        end
      end
    endcase
    if (!flowCtlOn) begin
      next_flowState = FLOW_NORMAL; // [R11]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      flowState <= FLOW_NORMAL;
      txHalt    <= 1'b0;
    end else begin
      flowState <= next_flowState;
      txHalt    <= (next_flowState == FLOW_HALTED); // [R14]
    end
  end

  always_comb begin
    unique case (flowState)
      FLOW_NORMAL:    flowField = 2'h0; // [R11]
      FLOW_HALT_PEND: flowField = 2'h1; // [R12]
      FLOW_RESTARTED: flowField = 2'h2; // [R13]
      FLOW_HALTED:    flowField = 2'h3; // [R14]
    endcase
  end

  assign haltedEvent = (next_flowState == FLOW_HALTED) && (flowState != FLOW_HALTED);

  ////////////////////////////////////////////////////////////////////////////////
  // transmit line flow character state, bits 1:0

  always_comb begin
    next_lineState = lineState;
    next_bitCount  = 4'h0;
    unique case (lineState)
      LINE_NORMAL: begin
        if (pauseSendRequest) begin
          next_lineState = LINE_PAUSE_PEND;
        end else if (resumeSendRequest) begin
          next_lineState = LINE_RESUME_PEND;
        end
      end
      LINE_PAUSE_PEND, LINE_RESUME_PEND: begin
        next_bitCount = bitTick ? bitCount + 4'h1 : bitCount;
        if ((lineState == LINE_PAUSE_PEND && autoPauseSent) ||
            (lineState == LINE_RESUME_PEND && autoResumeSent)) begin
          next_lineState = LINE_IDLE_WAIT;
          next_bitCount  = 4'h0;
        end else if (next_bitCount == `FCRS_CHAR_BITS) begin
          // a request the engine never served is dropped after a frame
          next_lineState = LINE_NORMAL; // [R16]
          next_bitCount  = 4'h0;
        end
      end
      LINE_IDLE_WAIT: begin
        if (bitTick && !txFifoEmpty) begin
          next_lineState = LINE_NORMAL;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      lineState    <= LINE_NORMAL;
      bitCount     <= 4'h0;
      txSendPause  <= 1'b0;
      txSendResume <= 1'b0;
    end else begin
      lineState    <= next_lineState;
      bitCount     <= next_bitCount;
      txSendPause  <= (next_lineState == LINE_PAUSE_PEND);
      txSendResume <= (next_lineState == LINE_RESUME_PEND);
    end
  end

  always_comb begin
    unique case (lineState)
      LINE_NORMAL:      lineField = 2'h0; // [R15]
      LINE_IDLE_WAIT:   lineField = 2'h1; // [R15]
      LINE_PAUSE_PEND:  lineField = 2'h2; // [R15]
      LINE_RESUME_PEND: lineField = 2'h3; // [R15]
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt status, write one to clear, set wins

  always_comb begin
    next_intStatus = intStatus;
    if (regWrite && regHit(regAddr, `FCRS_OFS_INT_STATUS)) begin
      next_intStatus = intStatus & ~regWrData[`FCRS_INT_BITS-1:0];
    end
    if (resumeMatch) begin
      next_intStatus[`FCRS_INT_RESUME_RX] = 1'b1;
    end
    if (pauseMatch) begin
      next_intStatus[`FCRS_INT_PAUSE_RX] = 1'b1;
    end
    if (wakeMatch) begin
      next_intStatus[`FCRS_INT_WAKE_RX] = 1'b1;
    end
    if (haltedEvent) begin
      next_intStatus[`FCRS_INT_TX_HALTED] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      intStatus <= '0;
      irq       <= 1'b0;
    end else begin
      intStatus <= next_intStatus;
      irq       <= |(next_intStatus & next_intMask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read data and outward pulses

  assign flowStatus = {rxField, txSentField, flowField, lineField};

  always_comb begin
    next_regRdData = 8'h00;
    if (regRead) begin
      unique case (regAddr)
        `FCRS_OFS_RESUME_CMP:  next_regRdData = resumeCompare;
        `FCRS_OFS_PAUSE_CMP:   next_regRdData = pauseCompare;
        `FCRS_OFS_WAKE_CMP:    next_regRdData = wakeCompare;
        `FCRS_OFS_FLOW_STATUS: next_regRdData = flowStatus; // [R4]
        `FCRS_OFS_CONTROL:     next_regRdData = control;
        `FCRS_OFS_INT_STATUS:  next_regRdData = {4'h0, intStatus};
        `FCRS_OFS_INT_MASK:    next_regRdData = {4'h0, intMask};
        default:               next_regRdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      regRdData        <= 8'h00;
      autoRxFlowEnable <= 1'b0;
      resumeSeen       <= 1'b0;
      pauseSeen        <= 1'b0;
      wakeSeen         <= 1'b0;
    end else begin
      regRdData        <= next_regRdData;
      autoRxFlowEnable <= next_control[`FCRS_CTL_AUTO_RX_FLOW];
      resumeSeen       <= resumeMatch; // [R17]
      pauseSeen        <= pauseMatch;  // [R17]
      wakeSeen         <= wakeMatch;   // [R17]
    end
  end

endmodule

`default_nettype wire

// >>> test_fcrs_top.sv
// self-checking bench of the flow character block
`timescale 1ns/1ps
`default_nettype none

module test_fcrs_top;
  logic       clk, reset, regWrite, regRead, txActive, txFifoEmpty;
  logic       rxCharValid, txHalt, irq;
  logic       txSendPause, txSendResume, autoRxFlowEnable, resumeSeen, pauseSeen, wakeSeen;
  logic [7:0] regAddr, regWrData, regRdData, rxChar;
  // bitTick, txCharDone, pause req, resume req, pause sent, resume sent
  logic [5:0] ev;
  int         n_mismatch, n_compared;

  fcrs_top i_dut (
    .clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .rxCharValid(rxCharValid), .rxChar(rxChar), .bitTick(ev[0]),
    .txActive(txActive), .txCharDone(ev[1]), .txFifoEmpty(txFifoEmpty),
    .pauseSendRequest(ev[2]), .resumeSendRequest(ev[3]), .autoPauseSent(ev[4]),
    .autoResumeSent(ev[5]), .txHalt(txHalt), .txSendPause(txSendPause),
    .txSendResume(txSendResume), .autoRxFlowEnable(autoRxFlowEnable),
    .resumeSeen(resumeSeen), .pauseSeen(pauseSeen), .wakeSeen(wakeSeen), .irq(irq)
  );
  fcrs_remote_station i_remote (.clk(clk), .rxCharValid(rxCharValid), .rxChar(rxChar));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  // compares only the bits under m
  task automatic rd(input logic [7:0] a, m, exp, input string what);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    check(what, exp, regRdData & m);
  endtask

  task automatic pulse(input logic [5:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 6'h00;
    repeat (2) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // pulses stand exactly one cycle, two cycles after the character
  task automatic seen_pulse(input logic [7:0] c, input logic [2:0] exp);
    fork
      i_remote.sendChar(c);
      begin
        repeat (3) @(posedge clk);
        #1 check("seen pulse", {5'h00, exp}, {5'h00, resumeSeen, pauseSeen, wakeSeen});
        @(posedge clk);
        #1 check("seen pulse end", 8'h00, {5'h00, resumeSeen, pauseSeen, wakeSeen});
      end
    join
  endtask

  task automatic t_regs;
    rd(8'h41, 8'hFF, 8'h11, "resume compare");
    rd(8'h42, 8'hFF, 8'h13, "pause compare");
    rd(8'h43, 8'hFF, 8'h00, "wake compare");
    rd(8'h50, 8'hFF, 8'h00, "unmapped");
    wr(8'h50, 8'h5A);
    wr(8'h41, 8'hA5);
    rd(8'h41, 8'hFF, 8'hA5, "resume written");
    wr(8'h41, 8'h11);
    wr(8'h43, 8'h5A);
    rd(8'h43, 8'hFF, 8'h5A, "wake written");
    $display("test registers done");
  endtask

  task automatic t_rx;
    i_remote.sendChar(8'h12);
    rd(8'h44, 8'hC0, 8'h00, "no flow char");
    i_remote.sendChar(8'h13);
    i_remote.sendChar(8'h5A);
    rd(8'h44, 8'hC0, 8'h40, "pause seen");
    rd(8'h44, 8'hC0, 8'h00, "seen cleared");
    i_remote.sendChar(8'h11);
    rd(8'h44, 8'hC0, 8'h80, "resume seen");
    i_remote.sendChar(8'h13);
    i_remote.sendChar(8'h11);
    // back to back reads: the second finds the field cleared
    @(posedge clk);
    regAddr <= 8'h44;
    regRead <= 1'b1;
    @(posedge clk);
    #1 check("both seen", 8'hC0, regRdData & 8'hC0);
    @(posedge clk);
    regRead <= 1'b0;
    #1 check("second read", 8'h00, regRdData & 8'hC0);
    rd(8'h49, 8'h07, 8'h07, "event status");
    seen_pulse(8'h11, 3'h4);
    seen_pulse(8'h13, 3'h2);
    seen_pulse(8'h5A, 3'h1);
    $display("test receive done");
  endtask

  task automatic t_irq;
    wr(8'h49, 8'h0F);
    wr(8'h4A, 8'h02);
    i_remote.sendChar(8'h11);
    #1 check("irq masked", 8'h00, {7'h00, irq});
    i_remote.sendChar(8'h13);
    #1 check("irq raised", 8'h01, {7'h00, irq});
    wr(8'h49, 8'h02);
    repeat (2) @(posedge clk);
    #1 check("irq cleared", 8'h00, {7'h00, irq});
    $display("test interrupt done");
  endtask

  task automatic t_txflow;
    wr(8'h48, 8'h02);
    rd(8'h44, 8'h0C, 8'h00, "tx normal");
    @(posedge clk);
    txActive <= 1'b1;
    i_remote.sendChar(8'h13);
    rd(8'h44, 8'h0C, 8'h04, "halt pending");
    check("no halt yet", 8'h00, {7'h00, txHalt});
    pulse(6'h02);
    @(posedge clk);
    txActive <= 1'b0;
    #1 check("halted", 8'h01, {7'h00, txHalt});
    rd(8'h44, 8'h0C, 8'h0C, "halt field");
    rd(8'h49, 8'h08, 8'h08, "halt event");
    i_remote.sendChar(8'h11);
    rd(8'h44, 8'h0C, 8'h08, "restarted");
    check("halt released", 8'h00, {7'h00, txHalt});
    rd(8'h44, 8'h0C, 8'h00, "normal again");
    wr(8'h48, 8'h00);
    $display("test transmit flow done");
  endtask

  task automatic t_auto;
    pulse(6'h10);
    rd(8'h44, 8'h30, 8'h00, "sent while off");
    wr(8'h48, 8'h01);
    #1 check("auto flow out", 8'h01, {7'h00, autoRxFlowEnable});
    pulse(6'h20);
    rd(8'h44, 8'h30, 8'h10, "resume sent");
    pulse(6'h30);
    rd(8'h44, 8'h30, 8'h30, "both sent");
    pulse(6'h10);
    wr(8'h48, 8'h00);
    rd(8'h44, 8'h30, 8'h00, "sent forced off");
    check("auto flow off", 8'h00, {7'h00, autoRxFlowEnable});
    pulse(6'h08);
    rd(8'h44, 8'h03, 8'h03, "resume pending");
    check("resume pend out", 8'h01, {6'h00, txSendPause, txSendResume});
    repeat (11) pulse(6'h01);
    rd(8'h44, 8'h03, 8'h03, "still pending");
    pulse(6'h01);
    rd(8'h44, 8'h03, 8'h00, "pending dropped");
    check("pend out dropped", 8'h00, {6'h00, txSendPause, txSendResume});
    pulse(6'h0C);
    rd(8'h44, 8'h03, 8'h02, "pause wins");
    check("pause pend out", 8'h02, {6'h00, txSendPause, txSendResume});
    pulse(6'h10);
    rd(8'h44, 8'h03, 8'h01, "idle wait");
    check("idle pend out", 8'h00, {6'h00, txSendPause, txSendResume});
    @(posedge clk);
    txFifoEmpty <= 1'b0;
    pulse(6'h01);
    rd(8'h44, 8'h03, 8'h00, "normal data");
    $display("test auto flow done");
  endtask

  task automatic wrap_up;
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    {reset, regWrite, regRead, txActive, txFifoEmpty} = 5'h11;
    {regAddr, regWrData, ev} = '0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_regs;
    t_rx;
    t_irq;
    t_txflow;
    t_auto;
    wrap_up;
  end

  // the tests need a few hundred cycles at most
  initial begin
    #50000;
    n_mismatch++;
    wrap_up;
  end
endmodule

`default_nettype wire
